// ---- src/rf_mode_consts.vh ----
// Constants for the transceiver operating-mode and radio-control block
//
// Summary of operation
// - Four output power levels from pa_power_level.
// - Burst: ramp amplifier up after lock, then down.
// - Ramp step times from ramp_up_step, ramp_down_step.
// - Synthesizer channel from rf_channel_index.
// - Synth on at mode fall; send after lock, ramp.
// - Pre-start timer from mode rise enables synthesizer.
// - Packet discarded if sending starts mid-load.
// - Refresh bit starts measurement, self-clears when done.
// - Digitised strength stored in signal_strength_value.
// - signal_strength_range selects one of two ranges.
// - Indicator asserted above threshold, polarity programmable.
// - Indicator output disabled while mode pin asserted.
// - Strength functions only in continuous transfer mode.
// - Three pins decode into five operating modes.
// - Sleep refuses serial access, loses configuration.
// - Leaving sleep runs 120 ms reset, restores defaults.
// - Stop keeps configuration, refuses serial access.
// - tx_rx_select chooses transmit or receive.
// - transfer_mode_select picks continuous or burst.
// - Standby enters active or configuration without delay.
`ifndef RF_MODE_CONSTS_VH
`define RF_MODE_CONSTS_VH

// ----------------
// Register offsets
// ----------------
`define REG_CHANNEL      5'h00
`define REG_POWER_XTAL   5'h01
`define REG_TRANSFER     5'h02
`define REG_REFRESH      5'h03
`define REG_STRENGTH     5'h04
`define REG_RAMP         5'h07
`define REG_PRESTART     5'h14
`define REG_INDICATOR    5'h17
`define REG_STATUS       5'h1f

// ----------------
// Field positions
// ----------------
`define CH_INDEX_MSB     6
`define TXRX_BIT         7
`define PA_LEVEL_MSB     1
`define XTAL_LSB         2
`define XTAL_MSB         4
`define RANGE_BIT        4
`define POL_BIT          0
`define THRESH_LSB       4

// ----------------
// Reset values
// ----------------
`define RST_CHANNEL      8'h00
`define RST_POWER_XTAL   8'h13
`define RST_TRANSFER     8'h00
`define RST_STRENGTH     8'h00
`define RST_RAMP         8'h00
`define RST_PRESTART     8'h00
`define RST_INDICATOR    8'h81

// ----------------
// Timing, in microseconds, clock rate and pre-start register limit
// ----------------
`define CYC_PER_US       20
`define POR_TIME_US      120000
`define LOCK_TIME_US     170
`define PRESTART_UNIT_US 20
`define PRESTART_MAX     8'hf9
`define RAMP_UNIT_US     5
`define SAMPLE_TIME_US   20

`endif

// ---- src/pin_sync.v ----
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
module pin_sync (
    input  wire clk,
    input  wire reset,
    input  wire pin,
    output reg  level
);
    reg stage1;
    reg stage2;
    reg stage3;

    // Level only moves once the second and third stages agree
    always @(posedge clk) begin
        if (reset) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
            level  <= 1'b0;
        end else begin
            stage1 <= pin;
            stage2 <= stage1;
            stage3 <= stage2;
            if (stage2 == stage3) begin
                level <= stage3;
            end
        end
    end
endmodule

// ---- src/rf_mode_control.v ----
// Operating-mode decode, synthesizer and amplifier sequencing, strength logic
`timescale 1ns/1ns
`include "rf_mode_consts.vh"
module rf_mode_control #(
    parameter POR_CYCLES = 22'h249f00
) (
    input  wire       clk,
    input  wire       reset,
    input  wire       power_state_pin,
    input  wire       config_select_pin,
    input  wire       mode_pin,
    input  wire [4:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_write,
    input  wire       reg_read,
    output reg  [7:0] reg_rdata,
    input  wire       tx_buffer_busy,
    input  wire       tx_done,
    input  wire [3:0] adc_value,
    output reg  [2:0] mode_state,
    output wire       serial_enable,
    output wire       synth_enable,
    output wire [6:0] synth_channel,
    output wire       pa_enable,
    output reg  [1:0] pa_stage,
    output wire       tx_data_enable,
    output reg        packet_discard,
    output wire       adc_range,
    output wire       measure_active,
    output wire       threshold_indicator_pin,
    output wire       threshold_indicator_oe
);
    // ----------------
    // Mode states and sequencer states
    // ----------------
    localparam ST_SLEEP   = 3'h0;
    localparam ST_POR     = 3'h1;
    localparam ST_STOP    = 3'h2;
    localparam ST_STANDBY = 3'h3;
    localparam ST_CONFIG  = 3'h4;
    localparam ST_ACTIVE  = 3'h5;
    localparam ST_BURST   = 3'h6;

    localparam SQ_IDLE     = 3'h0;
    localparam SQ_PRESTART = 3'h1;
    localparam SQ_LOCK     = 3'h2;
    localparam SQ_WAIT     = 3'h3;
    localparam SQ_RAMPUP   = 3'h4;
    localparam SQ_SEND     = 3'h5;
    localparam SQ_RAMPDN   = 3'h6;
    localparam SQ_RX       = 3'h7;

    localparam [16:0] LOCK_CYCLES   = `LOCK_TIME_US * `CYC_PER_US;
    localparam [16:0] PRE_UNIT      = `PRESTART_UNIT_US * `CYC_PER_US;
    localparam [16:0] RAMP_UNIT     = `RAMP_UNIT_US * `CYC_PER_US;
    localparam [16:0] SAMPLE_CYCLES = `SAMPLE_TIME_US * `CYC_PER_US;

    // ----------------
    // Pin synchronisation and edge detection
    // ----------------
    wire pwr_s;
    wire cfg_s;
    wire mode_n;
    reg  mode_d;

    pin_sync u_sync_pwr  (.clk(clk), .reset(reset), .pin(power_state_pin),   .level(pwr_s));
    pin_sync u_sync_cfg  (.clk(clk), .reset(reset), .pin(config_select_pin), .level(cfg_s));
    pin_sync u_sync_mode (.clk(clk), .reset(reset), .pin(~mode_pin),         .level(mode_n));
    // Mode synchronised inverted so reset reads as sleep, not a false wake
    wire mode_s = ~mode_n;

    // Edges come from filtered samples only
    always @(posedge clk) begin
        if (reset) begin
            mode_d <= 1'b1;
        end else begin
            mode_d <= mode_s;
        end
    end
    wire mode_rise = mode_s & ~mode_d;
    wire mode_fall = ~mode_s & mode_d;

    // ----------------
    // Configuration registers
    // ----------------
    reg [7:0] r_channel;
    reg [7:0] r_power_xtal;
    reg [7:0] r_transfer;
    reg       r_refresh;
    reg [7:0] r_strength;
    reg [7:0] r_ramp;
    reg [7:0] r_prestart;
    reg [7:0] r_indicator;

    wire       tx_select  = r_channel[`TXRX_BIT];
    wire       burst_mode = r_transfer[0];
    wire [1:0] pa_level   = r_power_xtal[`PA_LEVEL_MSB:0];
    wire [3:0] thresh     = r_indicator[7:`THRESH_LSB];
    wire [3:0] up_step    = r_ramp[3:0];
    wire [3:0] dn_step    = r_ramp[7:4];

    // No access in sleep, power-up reset or stop
    assign serial_enable = (mode_state == ST_STANDBY) || (mode_state == ST_CONFIG) ||
                           (mode_state == ST_ACTIVE)  || (mode_state == ST_BURST);
    wire wr_ok = reg_write & serial_enable;
    wire rd_ok = reg_read & serial_enable;
    wire meas_done;
    wire refresh_ok = ~burst_mode & (mode_state == ST_ACTIVE) & ~tx_select;

    // Sleep loses contents; defaults hold until the reset ends
    always @(posedge clk) begin
        if (reset || mode_state == ST_SLEEP || mode_state == ST_POR) begin
            r_channel    <= `RST_CHANNEL;
            r_power_xtal <= `RST_POWER_XTAL;
            r_transfer   <= `RST_TRANSFER;
            r_refresh    <= 1'b0;
            r_strength   <= `RST_STRENGTH;
            r_ramp       <= `RST_RAMP;
            r_prestart   <= `RST_PRESTART;
            r_indicator  <= `RST_INDICATOR;
        end else begin
            if (wr_ok) begin
                case (reg_addr)
                    `REG_CHANNEL:    r_channel    <= reg_wdata;
                    `REG_POWER_XTAL: r_power_xtal <= reg_wdata;
                    `REG_TRANSFER:   r_transfer   <= reg_wdata;
                    `REG_RAMP:       r_ramp       <= reg_wdata;
                    `REG_PRESTART:   r_prestart   <= reg_wdata;
                    `REG_INDICATOR:  r_indicator  <= reg_wdata;
                    default: ;
                endcase
            end
            // Range bit is writable, value field is hardware-owned
            if (wr_ok && reg_addr == `REG_STRENGTH) begin
                r_strength[`RANGE_BIT] <= reg_wdata[`RANGE_BIT];
            end
            if (meas_done) begin
                r_strength[3:0] <= adc_value;
            end
            // A new start written as the sample ends wins over the clear
            if (wr_ok && reg_addr == `REG_REFRESH && reg_wdata[0] && refresh_ok) begin
                r_refresh <= 1'b1;
            end else if (meas_done || !refresh_ok) begin
                r_refresh <= 1'b0;
            end
        end
    end

    // Read data one cycle after the strobe; refused reads give zero
    always @(posedge clk) begin
        if (reset) begin
            reg_rdata <= 8'h00;
        end else if (rd_ok) begin
            case (reg_addr)
                `REG_CHANNEL:    reg_rdata <= r_channel;
                `REG_POWER_XTAL: reg_rdata <= r_power_xtal;
                `REG_TRANSFER:   reg_rdata <= r_transfer;
                `REG_REFRESH:    reg_rdata <= {7'h00, r_refresh};
                `REG_STRENGTH:   reg_rdata <= r_strength;
                `REG_RAMP:       reg_rdata <= r_ramp;
                `REG_PRESTART:   reg_rdata <= r_prestart;
                `REG_INDICATOR:  reg_rdata <= r_indicator;
                `REG_STATUS:     reg_rdata <= {pa_enable, pa_stage, synth_enable, 1'b0,
                                               mode_state};
                default:         reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // ----------------
    // Operating-mode decoder
    // ----------------
    reg  [21:0] por_count;
    reg  [2:0]  next_mode;
    reg  [2:0]  seq;
    wire        seq_finished;

    // Pin combination to mode; undefined ones keep the current mode
    reg [2:0] pin_mode;
    always @* begin
        pin_mode = mode_state;
        if (!pwr_s && mode_s) begin
            pin_mode = ST_SLEEP;
        end else if (!pwr_s && !cfg_s && !mode_s) begin
            pin_mode = ST_STOP;
        end else if (pwr_s && !cfg_s && !mode_s) begin
            pin_mode = ST_STANDBY;
        end else if (pwr_s && cfg_s && !mode_s) begin
            pin_mode = ST_CONFIG;
        end else if (pwr_s && !cfg_s && mode_s) begin
            pin_mode = ST_ACTIVE;
        end
    end

    always @* begin
        next_mode = mode_state;
        case (mode_state)
            ST_SLEEP: begin
                if (pin_mode != ST_SLEEP) begin
                    next_mode = ST_POR;
                end
            end
            ST_POR: begin
                if (pin_mode == ST_SLEEP) begin
                    next_mode = ST_SLEEP;
                end else if (por_count == POR_CYCLES - 22'h000001) begin
                    next_mode = pin_mode;
                end
            end
            ST_ACTIVE: begin
                // Mode pin falling in burst transmit starts the packet
                if (pin_mode == ST_STANDBY && mode_fall && tx_select && burst_mode) begin
                    next_mode = ST_BURST;
                end else begin
                    next_mode = pin_mode;
                end
            end
            ST_BURST: begin
                if (pin_mode == ST_SLEEP) begin
                    next_mode = ST_SLEEP;
                end else if (seq_finished) begin
                    next_mode = pin_mode;
                end
            end
            ST_STOP, ST_STANDBY, ST_CONFIG: begin
                next_mode = pin_mode; // No start-up delay from standby
            end
            default: next_mode = ST_SLEEP;
        endcase
    end

    // Power-up reset counter runs only in its own state
    always @(posedge clk) begin
        if (reset) begin
            mode_state <= ST_SLEEP;
            por_count  <= 22'h000000;
        end else begin
            mode_state <= next_mode;
            if (mode_state == ST_POR) begin
                por_count <= por_count + 22'h000001;
            end else begin
                por_count <= 22'h000000;
            end
        end
    end

    // ----------------
    // Synthesizer and amplifier sequencer
    // ----------------
    reg  [16:0] timer;
    wire [7:0]  pre_sat    = (r_prestart > `PRESTART_MAX) ? `PRESTART_MAX : r_prestart;
    wire [16:0] pre_cycles = ({9'h000, pre_sat} + 17'h00001) * PRE_UNIT;
    wire [16:0] up_cycles  = ({13'h0000, up_step} + 17'h00001) * RAMP_UNIT;
    wire [16:0] dn_cycles  = ({13'h0000, dn_step} + 17'h00001) * RAMP_UNIT;
    wire        in_radio   = (next_mode == ST_ACTIVE) || (next_mode == ST_BURST);
    wire        timer_done = (timer == 17'h00000);
    wire        to_burst   = (next_mode == ST_BURST);

    assign seq_finished   = (seq == SQ_IDLE);
    assign synth_enable   = (seq != SQ_IDLE) && (seq != SQ_PRESTART);
    assign synth_channel  = r_channel[`CH_INDEX_MSB:0];
    assign pa_enable      = (seq == SQ_RAMPUP) || (seq == SQ_SEND) || (seq == SQ_RAMPDN);
    assign tx_data_enable = (seq == SQ_SEND); // Data only after lock and full ramp

    // Locking, ramping and sending; leaving the radio modes aborts at once
    always @(posedge clk) begin
        if (reset) begin
            seq            <= SQ_IDLE;
            timer          <= 17'h00000;
            pa_stage       <= 2'h0;
            packet_discard <= 1'b0;
        end else begin
            packet_discard <= 1'b0;
            if (!timer_done) begin
                timer <= timer - 17'h00001;
            end
            if (!in_radio) begin
                seq      <= SQ_IDLE;
                pa_stage <= 2'h0;
                timer    <= 17'h00000;
            end else begin
                case (seq)
                    SQ_IDLE: begin
                        if (next_mode == ST_ACTIVE && !tx_select) begin
                            seq   <= SQ_LOCK;
                            timer <= LOCK_CYCLES;
                        end else if (mode_rise && tx_select && burst_mode) begin
                            seq   <= SQ_PRESTART;
                            timer <= pre_cycles;
                        end else if (to_burst) begin
                            seq   <= SQ_LOCK;
                            timer <= LOCK_CYCLES;
                        end
                    end
                    SQ_PRESTART: begin
                        if (timer_done || to_burst) begin
                            seq   <= SQ_LOCK;
                            timer <= LOCK_CYCLES;
                        end
                    end
                    SQ_LOCK: begin
                        if (timer_done) begin
                            seq <= tx_select ? SQ_WAIT : SQ_RX;
                        end
                    end
                    SQ_WAIT: begin
                        // Locked early by pre-start: hold until the packet starts
                        if (mode_state == ST_BURST) begin
                            seq      <= SQ_RAMPUP;
                            pa_stage <= 2'h0;
                            timer    <= up_cycles;
                        end
                    end
                    SQ_RAMPUP: begin
                        if (timer_done) begin
                            if (pa_stage == pa_level) begin
                                if (tx_buffer_busy) begin
                                    packet_discard <= 1'b1;
                                    seq            <= SQ_RAMPDN;
                                    timer          <= dn_cycles;
                                end else begin
                                    seq <= SQ_SEND;
                                end
                            end else begin
                                pa_stage <= pa_stage + 2'h1;
                                timer    <= up_cycles;
                            end
                        end
                    end
                    SQ_SEND: begin
                        if (tx_done) begin
                            seq   <= SQ_RAMPDN;
                            timer <= dn_cycles;
                        end
                    end
                    SQ_RAMPDN: begin
                        if (timer_done) begin
                            if (pa_stage == 2'h0) begin
                                seq <= SQ_IDLE; // Amplifier fully off
                            end else begin
                                pa_stage <= pa_stage - 2'h1;
                                timer    <= dn_cycles;
                            end
                        end
                    end
                    SQ_RX: begin
                        seq <= SQ_RX;
                    end
                    default: seq <= SQ_IDLE;
                endcase
            end
        end
    end

    // ----------------
    // Signal-strength measurement and threshold indicator
    // ----------------
    reg [16:0] meas_timer;
    reg        meas_run;

    // A sample lasts a fixed time from the refresh write
    always @(posedge clk) begin
        if (reset || !r_refresh) begin
            meas_run   <= 1'b0;
            meas_timer <= 17'h00000;
        end else if (!meas_run) begin
            meas_run   <= 1'b1;
            meas_timer <= SAMPLE_CYCLES - 17'h00001;
        end else if (meas_timer != 17'h00000) begin
            meas_timer <= meas_timer - 17'h00001;
        end
    end
    assign meas_done      = meas_run && (meas_timer == 17'h00000);
    assign measure_active = r_refresh;
    assign adc_range      = r_strength[`RANGE_BIT];

    // Compare against threshold; off during mode pin and in burst mode
    wire above = (r_strength[3:0] > thresh);
    assign threshold_indicator_pin = above ? r_indicator[`POL_BIT] : ~r_indicator[`POL_BIT];
    assign threshold_indicator_oe  = ~mode_s & ~burst_mode & serial_enable;
endmodule

// ---- tb/rf_mode_control_props.sv ----
// Port-level checks for the mode-control block
`timescale 1ns/1ns
module rf_mode_control_props #(
    parameter POR_CYCLES = 22'h249f00
) (
    input wire       clk,
    input wire       reset,
    input wire       mode_pin,
    input wire       reg_read,
    input wire [7:0] reg_rdata,
    input wire       tx_buffer_busy,
    input wire [2:0] mode_state,
    input wire       serial_enable,
    input wire       synth_enable,
    input wire       pa_enable,
    input wire [1:0] pa_stage,
    input wire       tx_data_enable,
    input wire       packet_discard,
    input wire       threshold_indicator_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // ------------------------------------------------
    // Sequences
    // ------------------------------------------------
    sequence s_wake;
        $past(mode_state) == 3'h0 && mode_state == 3'h1;
    endsequence
    sequence s_stage_step;
        pa_stage == $past(pa_stage) + 2'h1 || pa_stage == $past(pa_stage) - 2'h1;
    endsequence
    // ------------------------------------------------
    // Assertions
    // ------------------------------------------------
    a_por_hold: assert property (s_wake |-> (mode_state == 3'h1)[*8])
        else $error("wake reset cut short");
    a_serial_modes: assert property (serial_enable == (mode_state >= 3'h3))
        else $error("bus access in wrong mode");
    a_read_refused: assert property ($past(reg_read && !serial_enable) |-> reg_rdata == 8'h00)
        else $error("refused read returned data");
    a_pa_after_lock: assert property (pa_enable |-> synth_enable)
        else $error("amplifier on without synthesizer");
    a_send_after_ramp: assert property (tx_data_enable |-> pa_enable && mode_state == 3'h6)
        else $error("sending outside burst ramp");
    a_stage_one_step: assert property ($changed(pa_stage) |-> s_stage_step)
        else $error("amplifier stage jumped");
    a_discard_cause: assert property (packet_discard |-> $past(tx_buffer_busy) ##1 !packet_discard)
        else $error("discard without late load");
    a_oe_mode_held: assert property (mode_pin [*8] |-> !threshold_indicator_oe)
        else $error("indicator driven with mode high");
    a_oe_no_burst: assert property (threshold_indicator_oe |-> serial_enable && mode_state != 3'h6)
        else $error("indicator driven in burst");
endmodule
bind rf_mode_control rf_mode_control_props #(.POR_CYCLES(POR_CYCLES)) u_props (.clk, .reset,
    .mode_pin, .reg_read, .reg_rdata, .tx_buffer_busy, .mode_state, .serial_enable,
    .synth_enable, .pa_enable, .pa_stage, .tx_data_enable, .packet_discard,
    .threshold_indicator_oe);

// ---- tb/host_model.sv ----
// Host model driving the mode pins and transmit-buffer status
`timescale 1ns/1ns
module host_model (
    input  wire clk,
    output reg  power_state_pin,
    output reg  config_select_pin,
    output reg  mode_pin,
    output reg  tx_buffer_busy,
    output reg  tx_done
);
    // Power up in sleep with no load running
    initial begin
        power_state_pin = 1'b0;
        config_select_pin = 1'b0;
        mode_pin = 1'b1;
        tx_buffer_busy = 1'b0;
        tx_done = 1'b0;
    end
    // Pins move together right after an edge, only to decoded modes
    task set_pins(input p, input c, input m);
        begin
            @(posedge clk);
            power_state_pin <= p;
            config_select_pin <= c;
            mode_pin <= m;
        end
    endtask
    // A late buffer load is only ever commanded by the bench
    task set_busy(input b);
        begin
            @(posedge clk);
            tx_buffer_busy <= b;
        end
    endtask
    // End-of-packet pulse, one cycle
    task pulse_done;
        begin
            @(posedge clk);
            tx_done <= 1'b1;
            @(posedge clk);
            tx_done <= 1'b0;
        end
    endtask
endmodule

// ---- tb/rf_mode_control_tb.sv ----
// Self-checking bench for the mode-control block
`timescale 1ns/1ns
module rf_mode_control_tb;
    localparam POR = 22'd50;
    reg        clk;
    reg        reset;
    reg  [4:0] reg_addr;
    reg  [7:0] reg_wdata;
    reg        reg_write;
    reg        reg_read;
    reg  [3:0] adc_value;
    wire [7:0] reg_rdata;
    wire [2:0] mode_state;
    wire [6:0] synth_channel;
    wire [1:0] pa_stage;
    wire       power_state_pin, config_select_pin, mode_pin, tx_buffer_busy, tx_done;
    wire       serial_enable, synth_enable, pa_enable, tx_data_enable, packet_discard;
    wire       adc_range, measure_active, threshold_indicator_pin, threshold_indicator_oe;
    integer    n_mismatch;
    integer    tests_run;
    integer    i;

    host_model u_host (.clk, .power_state_pin, .config_select_pin, .mode_pin,
        .tx_buffer_busy, .tx_done);
    rf_mode_control #(.POR_CYCLES(POR)) u_rf_mode_control (.clk, .reset, .power_state_pin,
        .config_select_pin, .mode_pin, .reg_addr, .reg_wdata, .reg_write, .reg_read,
        .reg_rdata, .tx_buffer_busy, .tx_done, .adc_value, .mode_state, .serial_enable,
        .synth_enable, .synth_channel, .pa_enable, .pa_stage, .tx_data_enable,
        .packet_discard, .adc_range, .measure_active, .threshold_indicator_pin,
        .threshold_indicator_oe);

    // Free-running 20 MHz clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // ------------------------------------------------
    // Tasks
    // ------------------------------------------------
    task print_verdict;
        begin
            $display("checks %0d mismatches %0d", tests_run, n_mismatch);
            if (n_mismatch == 0 && tests_run > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask
    task chk(input [7:0] got, input [7:0] exp);
        begin
            tests_run = tests_run + 1;
            if (got !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task step;
        begin
            @(posedge clk);
            #1 i = i + 1;
        end
    endtask
    // A wait that runs out ends the run as a mismatch
    task guard(input integer n);
        begin
            if (i >= n) begin
                n_mismatch = n_mismatch + 1;
                print_verdict;
            end
        end
    endtask
    task wr(input [4:0] a, input [7:0] d);
        begin
            @(posedge clk);
            reg_addr <= a;
            reg_wdata <= d;
            reg_write <= 1'b1;
            @(posedge clk);
            reg_write <= 1'b0;
            #1;
        end
    endtask
    // Read data stand only in the cycle after the strobe
    task rd(input [4:0] a, input [7:0] exp);
        begin
            @(posedge clk);
            reg_addr <= a;
            reg_read <= 1'b1;
            @(posedge clk);
            reg_read <= 1'b0;
            #1 chk(reg_rdata, exp);
        end
    endtask
    task wait_mode(input [2:0] s, input integer n);
        begin
            i = 0;
            while (mode_state !== s && i < n) step;
            guard(n);
        end
    endtask
    // Burst: mode held for hold cycles, then dropped; late load forces a discard
    task burst(input integer hold, input b);
        begin
            u_host.set_busy(b);
            u_host.set_pins(1'b1, 1'b0, 1'b1);
            repeat (hold) @(posedge clk);
            #1 chk({7'h00, synth_enable}, {7'h00, hold > 420});
            u_host.set_pins(1'b1, 1'b0, 1'b0);
            wait_mode(3'h6, 20);
            i = 0;
            while (pa_enable !== 1'b1 && i < 5000) step;
            guard(5000);
            chk({7'h00, i > 3000}, 8'h01);
            i = 0;
            while (tx_data_enable !== 1'b1 && packet_discard !== 1'b1 && i < 1000) step;
            guard(1000);
            chk({7'h00, packet_discard}, {7'h00, b});
            chk({6'h00, pa_stage}, 8'h03);
            chk({7'h00, i > 395 && i < 406}, 8'h01);
            if (!b) u_host.pulse_done;
            u_host.set_busy(1'b0);
            wait_mode(3'h3, 1000);
            chk({5'h00, pa_enable, pa_stage}, 8'h00);
        end
    endtask
    // ------------------------------------------------
    // Main sequence
    // ------------------------------------------------
    initial begin
        n_mismatch = 0;
        tests_run = 0;
        reset = 1'b1;
        reg_addr = 5'h00;
        reg_wdata = 8'h00;
        reg_write = 1'b0;
        reg_read = 1'b0;
        adc_value = 4'ha;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        rd(5'h01, 8'h00);
        u_host.set_pins(1'b1, 1'b0, 1'b0);
        wait_mode(3'h1, 20);
        wait_mode(3'h3, POR + 10);
        chk({7'h00, i > POR - 3}, 8'h01);
        rd(5'h01, 8'h13);
        rd(5'h17, 8'h81);
        rd(5'h1f, 8'h03);
        rd(5'h05, 8'h00);
        wr(5'h00, 8'h25);
        chk({1'b0, synth_channel}, 8'h25);
        u_host.set_pins(1'b1, 1'b1, 1'b0);
        wait_mode(3'h4, 10);
        wr(5'h01, 8'h11);
        rd(5'h01, 8'h11);
        u_host.set_pins(1'b0, 1'b0, 1'b0);
        wait_mode(3'h2, 10);
        wr(5'h01, 8'h12);
        rd(5'h01, 8'h00);
        u_host.set_pins(1'b1, 1'b0, 1'b0);
        repeat (30000) @(posedge clk); // Turn-on wait after stop
        rd(5'h01, 8'h11);
        u_host.set_pins(1'b0, 1'b1, 1'b1);
        wait_mode(3'h0, 10);
        u_host.set_pins(1'b1, 1'b0, 1'b0);
        wait_mode(3'h3, POR + 30);
        rd(5'h01, 8'h13);
        wr(5'h01, 8'h13); // Rewrite after sleep
        wr(5'h17, 8'h51);
        u_host.set_pins(1'b1, 1'b0, 1'b1);
        wait_mode(3'h5, 10);
        chk({7'h00, synth_enable}, 8'h01);
        wr(5'h03, 8'h01);
        chk({7'h00, measure_active}, 8'h01);
        i = 0;
        while (measure_active !== 1'b0 && i < 500) step;
        guard(500);
        chk({7'h00, i > 394 && i < 406}, 8'h01);
        rd(5'h04, 8'h0a);
        chk({7'h00, threshold_indicator_oe}, 8'h00);
        u_host.set_pins(1'b1, 1'b0, 1'b0);
        wait_mode(3'h3, 10);
        chk({6'h00, threshold_indicator_oe, threshold_indicator_pin}, 8'h03);
        wr(5'h17, 8'h50);
        chk({7'h00, threshold_indicator_pin}, 8'h00);
        wr(5'h04, 8'h1f);
        rd(5'h04, 8'h1a);
        chk({7'h00, adc_range}, 8'h01);
        wr(5'h00, 8'ha5);
        wr(5'h02, 8'h01);
        chk({7'h00, threshold_indicator_oe}, 8'h00);
        burst(450, 1'b0);
        burst(20, 1'b1);
        print_verdict;
    end
endmodule
